// ==== pmc_regs.sv ====
// APB register bank for power management capability and master timeout registers
//
// The APB register port is this design's own decision.
module pmc_regs
   import pmc_pkg::*;
#(
   parameter logic [3:0] PSTATE_IMPL = 4'b1111,
   parameter int TMO_WIDTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic pri_pending,
   input wire logic sec_pending,
   output logic pri_timeout,
   output logic sec_timeout,
   output logic [1:0] power_state,
   output logic chip_reset,
   output logic sec_bus_reset
);

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   typedef struct packed {
      logic [1:0] pstate;
      logic [15:0] pri_tmo;
      logic [15:0] sec_tmo;
      logic [31:0] rdata;
      logic wake;
      logic rvalid;
   } pmc_state_t;

   pmc_state_t st_reg;
   pmc_state_t st_next;

   logic access;
   logic wr;
   logic rd;
   logic [1:0] wr_pstate;

   // merges one 16-bit half of a word under its two byte strobes
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
                                           input logic [1:0] strb);
      logic [15:0] res;
      res = old;
      if (strb[0]) res[7:0] = nw[7:0];
      if (strb[1]) res[15:8] = nw[15:8];
      return res;
   endfunction

   // -------------------------------------------------------------------
   // read mux
   // -------------------------------------------------------------------
   function automatic logic [31:0] read_word(input logic [7:0] addr, input pmc_state_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (addr)
         PMC_OFF_CAP: begin
            w[7:0] = PMC_CAP_ID;
            w[15:8] = PMC_CAP_NEXT;
            w[PMC_POS_REV +: 3] = PMC_PM_REV;
            // bits 19,20,21,24:22,31:27 stay zero
            w[PMC_POS_D1] = 1'b1;
            w[PMC_POS_D2] = 1'b1;
         end
         PMC_OFF_CSR: begin
            // bits 15:2 stay zero: no wake enable or wake status bits, no data register
            w[1:0] = s.pstate;
         end
         PMC_OFF_TMO: begin
            w[15:0] = s.pri_tmo;
            w[PMC_POS_SEC_TMO +: 16] = s.sec_tmo;
         end
         PMC_OFF_SEC: begin
            w[7:0] = PMC_SEC_ID;
            w[15:8] = PMC_SEC_NEXT;
         end
         default: begin
            w = 32'h0000_0000;
         end
      endcase
      return w;
   endfunction

   // -------------------------------------------------------------------
   // bus decode
   // -------------------------------------------------------------------
   // writes complete in their first access cycle; reads take one wait state so that
   // prdata comes straight from a flip-flop yet already stands at the edge where pready is high
   assign access = psel && penable;
   assign wr = access && pwrite;
   assign rd = access && !pwrite;
   assign wr_pstate = pwdata[1:0];

   always_comb begin
      st_next = st_reg;
      st_next.wake = 1'b0;
      // load once, in the first access cycle of a read
      st_next.rvalid = rd && !st_reg.rvalid;
      if (rd && !st_reg.rvalid) begin
         st_next.rdata = read_word(paddr, st_reg);
      end
      if (wr && paddr == PMC_OFF_CSR && pstrb[0]) begin
         // an unimplemented state is dropped; the write still completes
         if (PSTATE_IMPL[wr_pstate]) begin
            st_next.pstate = wr_pstate;
            st_next.wake = (st_reg.pstate == PMC_D3) && (wr_pstate == PMC_D0);
         end
      end
      if (wr && paddr == PMC_OFF_TMO) begin
         st_next.pri_tmo = merge16(st_reg.pri_tmo, pwdata[15:0], pstrb[1:0]);
         st_next.sec_tmo = merge16(st_reg.sec_tmo, pwdata[31:16], pstrb[3:2]);
      end
      // writes anywhere else change nothing
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg.pstate <= PMC_D0;
         st_reg.pri_tmo <= PMC_TMO_RESET;
         st_reg.sec_tmo <= PMC_TMO_RESET;
         st_reg.rdata <= 32'h0000_0000;
         st_reg.wake <= 1'b0;
         st_reg.rvalid <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.rdata;
   assign pready = !rd || st_reg.rvalid;
   // unmapped addresses read zero and are not flagged as errors
   assign pslverr = 1'b0;
   assign power_state = st_reg.pstate;
   // the wake reset is internal only; the secondary bus reset stays idle
   assign sec_bus_reset = 1'b0;

   // -------------------------------------------------------------------
   // submodules
   // -------------------------------------------------------------------
   pmc_reset_gen u_rst (
      .pclk(pclk),
      .presetn(presetn),
      .start(st_reg.wake),
      .chip_reset(chip_reset)
   );

   pmc_timeout #(.WIDTH(TMO_WIDTH)) u_pri_tmo (
      .pclk(pclk),
      .presetn(presetn),
      .pending(pri_pending),
      .limit(st_reg.pri_tmo[TMO_WIDTH-1:0]),
      .expired(pri_timeout)
   );

   pmc_timeout #(.WIDTH(TMO_WIDTH)) u_sec_tmo (
      .pclk(pclk),
      .presetn(presetn),
      .pending(sec_pending),
      .limit(st_reg.sec_tmo[TMO_WIDTH-1:0]),
      .expired(sec_timeout)
   );

   // -------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------
   chk_cap_word_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CAP |=> prdata == 32'h0602_9001)
      else $error("capability word wrong");

   chk_next_ptr_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CAP |=> prdata[15:8] == 8'h90)
      else $error("next pointer wrong");

   chk_rev_field: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CAP |=> prdata[18:16] == 3'b010 && prdata[21:19] == 3'b000)
      else $error("revision or fixed zero bits wrong");

   chk_wake_bits_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CAP |=> prdata[31:27] == 5'h00 && prdata[26:25] == 2'b11)
      else $error("wake support or D1/D2 bits wrong");

   chk_csr_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CSR |=> prdata[31:2] == 30'h0 && prdata[1:0] == $past(st_reg.pstate))
      else $error("control word high bits not zero");

   chk_pstate_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == PMC_OFF_CSR && pstrb[0] && PSTATE_IMPL[pwdata[1:0]]
      |=> power_state == $past(pwdata[1:0]))
      else $error("power state not written");

   chk_pstate_unimpl: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == PMC_OFF_CSR && !PSTATE_IMPL[pwdata[1:0]] |=> $stable(power_state))
      else $error("unimplemented power state accepted");

   chk_wake_reset: assert property (@(posedge pclk) disable iff (!presetn)
      power_state == PMC_D3 && wr && paddr == PMC_OFF_CSR && pstrb[0] && pwdata[1:0] == 2'b00
      |=> ##1 chip_reset && !sec_bus_reset)
      else $error("wake from D3 did not reset chip");

   chk_tmo_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == PMC_OFF_TMO && pstrb == 4'hf
      |=> st_reg.pri_tmo == $past(pwdata[15:0]) && st_reg.sec_tmo == $past(pwdata[31:16]))
      else $error("timeout values not written");

   chk_sec_cap_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_SEC |=> prdata == 32'h0000_0006)
      else $error("second capability header wrong");

   chk_ro_write_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr != PMC_OFF_CSR && paddr != PMC_OFF_TMO |=> $stable(st_reg.pstate)
      && $stable(st_reg.pri_tmo) && $stable(st_reg.sec_tmo))
      else $error("write to read-only space changed state");

   chk_read_wait: assert property (@(posedge pclk) disable iff (!presetn)
      rd && !st_reg.rvalid |-> !pready)
      else $error("read answered before its data was loaded");

   chk_read_done: assert property (@(posedge pclk) disable iff (!presetn)
      rd && !st_reg.rvalid |=> pready)
      else $error("read not answered after one wait state");

   chk_write_nowait: assert property (@(posedge pclk) disable iff (!presetn)
      wr |-> pready && !pslverr)
      else $error("write not completed normally");

   chk_cap_id_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CAP |=> prdata[7:0] == 8'h01)
      else $error("capability id wrong");

   chk_pm_clock_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CAP |=> !prdata[19])
      else $error("wake clock bit set");

   chk_aux_power_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CAP |=> !prdata[20])
      else $error("auxiliary power bit set");

   chk_dev_init_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CAP |=> !prdata[21])
      else $error("device init bit set");

   chk_d1_d2_bits: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CAP |=> prdata[26:25] == 2'b11)
      else $error("D1 or D2 support bit clear");

   chk_cap_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CAP |=> prdata[24:22] == 3'b000)
      else $error("reserved capability bits set");

   chk_csr_state_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CSR |=> prdata[1:0] == $past(power_state))
      else $error("power state read back wrong");

   chk_wake_enable_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CSR |=> !prdata[8])
      else $error("wake enable bit set");

   chk_data_fields_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CSR |=> prdata[14:9] == 6'h00)
      else $error("data select or scale not zero");

   chk_wake_status_zero: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_CSR |=> !prdata[15])
      else $error("wake status bit set");

   chk_tmo_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_TMO |=> prdata == {$past(st_reg.sec_tmo), $past(st_reg.pri_tmo)})
      else $error("timeout values read back wrong");

   chk_pri_tmo_write: assert property (@(posedge pclk) disable iff (!presetn)
      wr && paddr == PMC_OFF_TMO && pstrb[1:0] == 2'b11 |=> st_reg.pri_tmo == $past(pwdata[15:0]))
      else $error("primary timeout not written");

   chk_sec_id_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_SEC |=> prdata[7:0] == 8'h06)
      else $error("second capability id wrong");

   chk_list_end: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr == PMC_OFF_SEC |=> prdata[15:8] == 8'h00)
      else $error("capability list not terminated");

   chk_unmapped_read: assert property (@(posedge pclk) disable iff (!presetn)
      rd && paddr != PMC_OFF_CAP && paddr != PMC_OFF_CSR && paddr != PMC_OFF_TMO && paddr != PMC_OFF_SEC
      |=> prdata == 32'h0000_0000)
      else $error("unmapped address read nonzero");

   chk_sec_reset_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !sec_bus_reset)
      else $error("secondary bus reset driven");

   chk_reset_needs_wake: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(chip_reset) |-> $past(st_reg.wake))
      else $error("chip reset without wake");

   chk_pstate_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr && paddr == PMC_OFF_CSR) |=> $stable(power_state))
      else $error("power state changed without a write");

   chk_tmo_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr && paddr == PMC_OFF_TMO) |=> $stable(st_reg.pri_tmo) && $stable(st_reg.sec_tmo))
      else $error("timeout value changed without a write");

endmodule

// ==== pmc_pkg.sv ====
// package: register map, field layout, reset values and types of the power management register group
package pmc_pkg;

   // -------------------------------------------------------------------
   // register offsets (byte addresses)
   // -------------------------------------------------------------------
   localparam logic [7:0] PMC_OFF_CAP = 8'h80;
   localparam logic [7:0] PMC_OFF_CSR = 8'h84;
   localparam logic [7:0] PMC_OFF_TMO = 8'h88;
   localparam logic [7:0] PMC_OFF_SEC = 8'h90;
   localparam logic [7:0] PMC_OFF_RST = 8'h98;

   // -------------------------------------------------------------------
   // fixed field values
   // -------------------------------------------------------------------
   localparam logic [7:0] PMC_CAP_ID = 8'h01;
   localparam logic [7:0] PMC_CAP_NEXT = 8'h90;
   localparam logic [2:0] PMC_PM_REV = 3'h2;
   localparam logic [7:0] PMC_SEC_ID = 8'h06;
   localparam logic [7:0] PMC_SEC_NEXT = 8'h00;

   // -------------------------------------------------------------------
   // field positions
   // -------------------------------------------------------------------
   localparam int PMC_POS_NEXT = 8;
   localparam int PMC_POS_REV = 16;
   localparam int PMC_POS_D1 = 25;
   localparam int PMC_POS_D2 = 26;
   localparam int PMC_POS_SEC_TMO = 16;

   // -------------------------------------------------------------------
   // reset values and timing
   // -------------------------------------------------------------------
   localparam logic [15:0] PMC_TMO_RESET = 16'h8000;
   localparam int PMC_CHIP_RESET_NS = 16;
   localparam int PMC_CLK_NS = 4;
   localparam int PMC_CHIP_RESET_CYC = (PMC_CHIP_RESET_NS + PMC_CLK_NS - 1) / PMC_CLK_NS;

   typedef enum logic [1:0] {
      PMC_D0 = 2'b00,
      PMC_D1 = 2'b01,
      PMC_D2 = 2'b10,
      PMC_D3 = 2'b11
   } pmc_pstate_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } pmc_apb_req_t;

   typedef struct packed {
      logic pending;
      logic expired;
   } pmc_tmo_t;

endpackage

// ==== pmc_timeout.sv ====
// master timeout counter for one bus interface
module pmc_timeout
   import pmc_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pending,
   input wire logic [WIDTH-1:0] limit,
   output logic expired
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic expired;
   } pmc_tmo_state_t;

   pmc_tmo_state_t st_reg;
   pmc_tmo_state_t st_next;

   // -------------------------------------------------------------------
   // counting
   // -------------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      st_next.expired = 1'b0;
      if (!pending) begin
         st_next.count = '0;
      end else if (st_reg.count != limit) begin
         st_next.count = st_reg.count + 1'b1;
         // fires once, on the clock the programmed count is reached
         st_next.expired = (st_reg.count + 1'b1) == limit;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign expired = st_reg.expired;

   chk_tmo_fire_count: assert property (@(posedge pclk) disable iff (!presetn)
      expired |-> $past(pending) && st_reg.count == limit)
      else $error("timeout fired before count reached limit");

   chk_tmo_idle_clear: assert property (@(posedge pclk) disable iff (!presetn)
      !$past(pending) |-> st_reg.count == '0 && !expired)
      else $error("timeout counter not cleared when idle");

endmodule

// ==== pmc_reset_gen.sv ====
// internal chip reset pulse generator, started by a power state wake
module pmc_reset_gen
   import pmc_pkg::*;
#(
   parameter int CYCLES = PMC_CHIP_RESET_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic start,
   output logic chip_reset
);

   typedef struct packed {
      logic [7:0] count;
      logic active;
   } pmc_rst_state_t;

   pmc_rst_state_t st_reg;
   pmc_rst_state_t st_next;

   always_comb begin
      st_next = st_reg;
      if (start) begin
         st_next.active = 1'b1;
         st_next.count = 8'(CYCLES - 1);
      end else if (st_reg.active) begin
         if (st_reg.count == 8'h00) begin
            st_next.active = 1'b0;
         end else begin
            st_next.count = st_reg.count - 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign chip_reset = st_reg.active;

   chk_rst_pulse_start: assert property (@(posedge pclk) disable iff (!presetn)
      start |=> chip_reset [*4])
      else $error("chip reset pulse shorter than expected");

endmodule

// ==== power_mgmt_capability_regs_test.sv ====
// self-checking bench for the power management register bank
module power_mgmt_capability_regs_test import pmc_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------
   // signals and design
   // ----------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic pri_pending = 1'b0;
   logic sec_pending = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic pri_timeout;
   logic sec_timeout;
   logic [1:0] power_state;
   logic chip_reset;
   logic sec_bus_reset;
   logic [31:0] rd;
   int n_fail = 0;
   int n_tests = 0;
   int n_crst = 0;
   int n_sbr = 0;
   int n_pto = 0;
   int n_sto = 0;

   typedef struct packed {
      logic w;
      logic [7:0] a;
      logic [31:0] d;
      logic [3:0] s;
      logic [31:0] e;
      logic [31:0] m;
   } pmc_row_t;

   // D2 left unimplemented so that ignored state writes can be seen
   pmc_regs #(.PSTATE_IMPL(4'hb), .TMO_WIDTH(16)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pri_pending(pri_pending), .sec_pending(sec_pending),
      .pri_timeout(pri_timeout), .sec_timeout(sec_timeout), .power_state(power_state),
      .chip_reset(chip_reset), .sec_bus_reset(sec_bus_reset));

   initial begin
      forever #2 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      if (chip_reset === 1'b1) n_crst++;
      if (sec_bus_reset !== 1'b0) n_sbr++;
      if (pri_timeout === 1'b1) n_pto++;
      if (sec_timeout === 1'b1) n_sto++;
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // read data is taken at the very edge where pready is seen high, as any master would
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      if (pready !== 1'b1) begin
         n_fail++;
         wrap_up();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // pulse must come after the programmed wait and only once per episode
   task automatic tmo(input logic s, input int lim);
      n_pto = 0;
      n_sto = 0;
      @(posedge pclk);
      pri_pending <= !s;
      sec_pending <= s;
      repeat (lim - 1) @(posedge pclk);
      #1 chk("early pulse", 32'h0000_0000, 32'(n_pto + n_sto));
      repeat (20) @(posedge pclk);
      #1 chk("pri pulses", {31'h0, !s}, 32'(n_pto));
      chk("sec pulses", {31'h0, s}, 32'(n_sto));
      n_pto = 0;
      n_sto = 0;
      @(posedge pclk);
      pri_pending <= 1'b0;
      sec_pending <= 1'b0;
      @(posedge pclk);
      pri_pending <= !s;
      sec_pending <= s;
      repeat (2) @(posedge pclk);
      pri_pending <= 1'b0;
      sec_pending <= 1'b0;
      repeat (20) @(posedge pclk);
      #1 chk("aborted wait", 32'h0000_0000, 32'(n_pto + n_sto));
   endtask

   localparam pmc_row_t ROWS [15] = '{
      '{1'b0, 8'h80, 32'h0000_0000, 4'h0, 32'h0602_9001, 32'hffff_ffff},
      '{1'b0, 8'h84, 32'h0000_0000, 4'h0, 32'h0000_0000, 32'hffff_ffff},
      '{1'b0, 8'h88, 32'h0000_0000, 4'h0, 32'h8000_8000, 32'hffff_ffff},
      '{1'b0, 8'h90, 32'h0000_0000, 4'h0, 32'h0000_0006, 32'h0000_ffff},
      '{1'b1, 8'h80, 32'hffff_ffff, 4'hf, 32'h0602_9001, 32'hffff_ffff},
      '{1'b1, 8'h84, 32'hffff_fffe, 4'hf, 32'h0000_0000, 32'hffff_ffff},
      '{1'b1, 8'h84, 32'hffff_fffd, 4'hf, 32'h0000_0001, 32'hffff_ffff},
      '{1'b1, 8'h84, 32'h0000_0002, 4'hf, 32'h0000_0001, 32'hffff_ffff},
      '{1'b1, 8'h84, 32'h0000_0003, 4'hf, 32'h0000_0003, 32'hffff_ffff},
      '{1'b1, 8'h88, 32'h1234_5678, 4'hf, 32'h1234_5678, 32'hffff_ffff},
      '{1'b1, 8'h88, 32'haaaa_bbbb, 4'h3, 32'h1234_bbbb, 32'hffff_ffff},
      '{1'b1, 8'h88, 32'hcccc_dddd, 4'hc, 32'hcccc_bbbb, 32'hffff_ffff},
      '{1'b1, 8'h90, 32'hffff_ffff, 4'hf, 32'h0000_0006, 32'h0000_ffff},
      '{1'b0, 8'h98, 32'h0000_0000, 4'h0, 32'h0000_0000, 32'hffff_ffff},
      '{1'b1, 8'h84, 32'h0000_0000, 4'he, 32'h0000_0003, 32'hffff_ffff}
   };

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ROWS[i]) begin
         if (ROWS[i].w) apb(1'b1, ROWS[i].a, ROWS[i].d, ROWS[i].s);
         apb(1'b0, ROWS[i].a, 32'h0000_0000, 4'h0);
         chk($sformatf("row %0d at %h", i, ROWS[i].a), ROWS[i].e, rd & ROWS[i].m);
      end
      $display("register table done");
      n_crst = 0;
      apb(1'b1, 8'h84, 32'h0000_0000, 4'hf);
      repeat (12) @(posedge pclk);
      #1 chk("wake reset cycles", 32'h0000_0004, 32'(n_crst));
      chk("power_state", 32'h0000_0000, {30'h0, power_state});
      n_crst = 0;
      apb(1'b1, 8'h84, 32'h0000_0003, 4'hf);
      apb(1'b1, 8'h84, 32'h0000_0001, 4'hf);
      apb(1'b1, 8'h84, 32'h0000_0000, 4'hf);
      apb(1'b1, 8'h84, 32'h0000_0000, 4'hf);
      repeat (12) @(posedge pclk);
      #1 chk("no wake reset", 32'h0000_0000, 32'(n_crst));
      $display("wake test done");
      apb(1'b1, 8'h88, 32'h0008_0005, 4'hf);
      tmo(1'b0, 5);
      tmo(1'b1, 8);
      $display("timeout test done");
      apb(1'b1, 8'h84, 32'h0000_0001, 4'hf);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      #1 chk("state in reset", 32'h0000_0000, {30'h0, power_state});
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, 8'h88, 32'h0000_0000, 4'h0);
      chk("timeouts after reset", 32'h8000_8000, rd);
      chk("secondary reset", 32'h0000_0000, 32'(n_sbr));
      $display("reset test done");
      wrap_up();
   end
endmodule
